/* File: rtl/counter_pkg.sv */
// Purpose: Constants and carrier types for the preset event counter bank.
// Assumes: APB slave with 32-bit data and 8-bit byte addresses.
// Notes: Shared by the counter core and its verification.
//
// What this block does
// RL1: Up/down counter steps up on count-up edges, down on count-down edges.
// RL2: Up/down count at 32767 wraps to -32768 on a count-up edge.
// RL3: Up/down count at -32768 wraps to 32767 on a count-down edge.
// RL4: Compare bit of up and up/down counters is high while count >= preset.
// RL5: Preset is compared with the count at every evaluation.
// RL6: Reset input or reset command clears the counter bit and the count.
// RL7: Up counter counts up and holds at 32767.
// RL8: Down counter counts down to 0 and its bit is high at 0.
// RL9: Power-up clears all counter bits; retained slots keep their count.
// RL10: Slots 0 to 255; all counter kinds on one slot share one count.
// RL11: Software should not give one slot number to two counters.
// RL12: Alt up counter stops at preset; output high when count >= preset.
// RL13: Alternative down counter loads preset, counts down, stops at zero.
// RL14: Alternative up/down flags: upper when count equals preset, zero at 0.
// RL15: Alternative up/down loads preset or zero and stops at preset or 0.
// RL16: Edges found against the input level at the slot's last evaluation.
// RL17: Reset beats load, and both beat a count edge.
// RL18: Count and preset are signed 16-bit two's complement.

package counter_pkg;

  // ****************************************
  // Sizes and limits
  // ****************************************
  localparam int unsigned NUM_SLOTS = 256;
  localparam int unsigned SLOT_W = 8;
  localparam int unsigned RETAIN_WORDS = 8;
  localparam logic signed [15:0] CNT_MAX = 16'sh7FFF;
  localparam logic signed [15:0] CNT_MIN = 16'sh8000;
  localparam logic signed [15:0] CNT_ZERO = 16'sh0000;
  localparam logic signed [15:0] CNT_ONE = 16'sh0001;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SLOT_SEL = 8'h04;
  localparam logic [7:0] OFS_SLOT_RD = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0C;
  localparam logic [7:0] OFS_RETAIN = 8'h20;
  localparam logic [7:0] OFS_RETAIN_END = 8'h3C;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CMD_GO_BIT = 8;
  localparam int unsigned RD_BIT_POS = 16;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [7:0] SLOT_SEL_RST = 8'h00;

  // ****************************************
  // Counter kinds and carriers
  // ****************************************
  typedef enum logic [2:0] {
    KIND_UP = 3'b000,
    KIND_DOWN = 3'b001,
    KIND_UP_DOWN = 3'b010,
    KIND_ALT_UP = 3'b011,
    KIND_ALT_DOWN = 3'b100,
    KIND_ALT_UP_DOWN = 3'b101
  } kind_t;

  typedef struct packed {
    logic valid;
    logic [7:0] slot;
    kind_t kind;
    logic count_up_input;
    logic count_down_input;
    logic load_input;
    logic reset_input;
    logic signed [15:0] preset_value;
  } eval_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] slot;
    logic counter_bit;
    logic upper_reached_flag;
    logic zero_reached_flag;
    logic signed [15:0] current_count;
  } eval_rsp_t;

endpackage

/* File: rtl/preset_event_counter.sv */
// Purpose: Bank of 256 signed event counters evaluated on request.
// Assumes: Evaluation requests come from logic on clk; APB on clk too.
// Notes: One evaluation per cycle; answer registered one cycle later.
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module preset_event_counter
  import counter_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Evaluation request and answer
  input wire eval_req_t req,
  output eval_rsp_t rsp,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ****************************************
  // Storage
  // ****************************************
  logic signed [15:0] count_mem [NUM_SLOTS];
  logic bit_r [NUM_SLOTS];
  logic prev_up_r [NUM_SLOTS];
  logic prev_dn_r [NUM_SLOTS];
  logic [31:0] retain_r [RETAIN_WORDS];
  logic [31:0] ctrl_r;
  logic [7:0] sel_r;
  logic [31:0] prdata_r;
  eval_rsp_t rsp_r;

  // ****************************************
  // APB decode
  // ****************************************
  wire logic setup_w = ce & psel & ~penable;
  wire logic access_w = ce & psel & penable;
  wire logic wr_w = access_w & pwrite;
  wire logic hit_ctrl = (paddr == OFS_CTRL);
  wire logic hit_sel = (paddr == OFS_SLOT_SEL);
  wire logic hit_rd = (paddr == OFS_SLOT_RD);
  wire logic hit_cmd = (paddr == OFS_CMD);
  wire logic hit_ret = (paddr >= OFS_RETAIN) && (paddr <= OFS_RETAIN_END)
                       && (paddr[1:0] == 2'b00);
  wire logic [2:0] ret_idx = 3'((paddr - OFS_RETAIN) >> 2);
  wire logic mapped_w = hit_ctrl | hit_sel | hit_rd | hit_cmd | hit_ret;
  // Slot readout and command word are read-only and write-only
  wire logic bad_w = ~mapped_w | (hit_rd & pwrite) | (hit_cmd & ~pwrite);
  wire logic cmd_clr = wr_w & hit_cmd & pwdata[CMD_GO_BIT]; // RL6
  wire logic [7:0] cmd_slot = pwdata[7:0];
  wire logic signed [15:0] sel_count = count_mem[sel_r];
  wire logic sel_bit = bit_r[sel_r];
  wire logic [31:0] rd_mux =
    hit_ctrl ? ctrl_r :
    hit_sel ? {24'h00_0000, sel_r} :
    hit_rd ? {15'h0000, sel_bit, sel_count} :
    hit_ret ? retain_r[ret_idx] : 32'h0000_0000;

  assign pready = access_w;
  assign pslverr = access_w & bad_w;
  assign prdata = prdata_r;

  // Read data captured in setup so it comes from a flop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_w) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r <= CTRL_RST;
      sel_r <= SLOT_SEL_RST;
    end else if (wr_w && !bad_w) begin
      if (hit_ctrl) begin
        ctrl_r <= pwdata & CTRL_RST;
      end
      if (hit_sel) begin
        sel_r <= pwdata[7:0];
      end
    end
  end

  // Retention mask survives sys_rst so kept counts stay meaningful
  for (genvar w = 0; w < RETAIN_WORDS; w++) begin : g_ret
    always_ff @(posedge clk) begin
      if (ce && wr_w && !bad_w && hit_ret && ret_idx == 3'(w)) begin
        retain_r[w] <= pwdata;
      end
    end
  end

  // ****************************************
  // Evaluation
  // ****************************************
  wire logic go_w = ce & req.valid & ctrl_r[CTRL_EN_BIT];
  wire logic signed [15:0] cur = count_mem[req.slot]; // RL10
  wire logic signed [15:0] pv = req.preset_value; // RL18
  wire logic up_e = req.count_up_input & ~prev_up_r[req.slot]; // RL16
  wire logic dn_e = req.count_down_input & ~prev_dn_r[req.slot]; // RL16
  wire logic rst_in = req.reset_input;
  wire logic ld_in = req.load_input;
  wire logic signed [15:0] cur_inc = cur + CNT_ONE;
  wire logic signed [15:0] cur_dec = cur - CNT_ONE;
  // A command reset on the same slot blocks the evaluation's slot update, but not its answer
  wire logic upd_w = go_w & ~(cmd_clr & (cmd_slot == req.slot));
  logic signed [15:0] nxt;
  logic cbit;

  always_comb begin
    nxt = cur;
    case (req.kind)
      KIND_UP: begin
        if (rst_in) nxt = CNT_ZERO; // RL6
        else if (up_e && cur != CNT_MAX) nxt = cur_inc; // RL7
      end
      KIND_DOWN: begin
        if (rst_in) nxt = CNT_ZERO; // RL17
        else if (ld_in) nxt = pv; // RL17
        else if (dn_e && cur > CNT_ZERO) nxt = cur_dec; // RL8
      end
      KIND_UP_DOWN: begin
        // Plain add wraps at the signed limits
        if (rst_in) nxt = CNT_ZERO; // RL6
        else if (up_e && !dn_e) nxt = cur_inc; // RL1 RL2
        else if (dn_e && !up_e) nxt = cur_dec; // RL1 RL3
      end
      KIND_ALT_UP: begin
        if (rst_in) nxt = CNT_ZERO; // RL12
        else if (up_e && cur < pv) nxt = cur_inc; // RL12
      end
      KIND_ALT_DOWN: begin
        if (rst_in) nxt = CNT_ZERO; // RL17
        else if (ld_in) nxt = pv; // RL13
        else if (dn_e && cur > CNT_ZERO) nxt = cur_dec; // RL13
      end
      KIND_ALT_UP_DOWN: begin
        if (rst_in) nxt = CNT_ZERO; // RL15
        else if (ld_in) nxt = pv; // RL15
        else if (up_e && !dn_e && cur != pv) nxt = cur_inc; // RL15
        else if (dn_e && !up_e && cur != CNT_ZERO) nxt = cur_dec; // RL15
      end
      default: nxt = cur;
    endcase
  end

  wire logic upper_w = (nxt == pv); // RL14
  wire logic zero_w = (nxt == CNT_ZERO); // RL14

  always_comb begin
    case (req.kind)
      KIND_DOWN, KIND_ALT_DOWN: cbit = zero_w; // RL8 RL13
      KIND_ALT_UP_DOWN: cbit = upper_w;
      default: cbit = (nxt >= pv); // RL4 RL5 RL12
    endcase
    // Reset clears the bit even where a zero count would set it
    if (rst_in) cbit = 1'b0; // RL6
  end

  // Per-slot state; slot number picks the one entry to update
  for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot
    wire logic ret_w = retain_r[i / 32][i % 32];
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        bit_r[i] <= 1'b0; // RL9
        prev_up_r[i] <= 1'b0;
        prev_dn_r[i] <= 1'b0;
        if (!ret_w) begin
          count_mem[i] <= CNT_ZERO; // RL9
        end
      end else if (ce) begin
        if (cmd_clr && cmd_slot == SLOT_W'(i)) begin
          count_mem[i] <= CNT_ZERO; // RL6
          bit_r[i] <= 1'b0; // RL6
        end else if (upd_w && req.slot == SLOT_W'(i)) begin
          count_mem[i] <= nxt;
          bit_r[i] <= cbit; // RL5
          prev_up_r[i] <= req.count_up_input; // RL16
          prev_dn_r[i] <= req.count_down_input; // RL16
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsp_r <= '0;
    end else if (ce) begin
      rsp_r.valid <= go_w;
      if (go_w) begin
        rsp_r.slot <= req.slot;
        rsp_r.counter_bit <= cbit;
        rsp_r.upper_reached_flag <= upper_w;
        rsp_r.zero_reached_flag <= zero_w;
        rsp_r.current_count <= nxt;
      end
    end
  end

  assign rsp = rsp_r;

  // ****************************************
  // Assertions
  // ****************************************
  wire logic plain_w = go_w & ~rst_in & ~ld_in;

  property p_ud_step;
    @(posedge clk) disable iff (sys_rst)
    plain_w && req.kind == KIND_UP_DOWN && up_e && !dn_e
    |=> rsp.current_count == $past(cur_inc) && rsp.valid;
  endproperty
  a_ud_step: assert property (p_ud_step) // RL1
    else $error("up/down counter did not step up");

  property p_wrap_max;
    @(posedge clk) disable iff (sys_rst)
    plain_w && req.kind == KIND_UP_DOWN && up_e && !dn_e && cur == CNT_MAX
    |=> rsp.current_count == CNT_MIN;
  endproperty
  a_wrap_max: assert property (p_wrap_max) // RL2
    else $error("count did not wrap from max to min");

  property p_wrap_min;
    @(posedge clk) disable iff (sys_rst)
    plain_w && req.kind == KIND_UP_DOWN && dn_e && !up_e && cur == CNT_MIN
    |=> rsp.current_count == CNT_MAX;
  endproperty
  a_wrap_min: assert property (p_wrap_min) // RL3
    else $error("count did not wrap from min to max");

  property p_cmp_bit;
    @(posedge clk) disable iff (sys_rst)
    go_w && !rst_in && (req.kind == KIND_UP || req.kind == KIND_UP_DOWN)
    |=> rsp.counter_bit == (rsp.current_count >= $past(pv));
  endproperty
  a_cmp_bit: assert property (p_cmp_bit) // RL4
    else $error("compare bit disagrees with count and preset");

  property p_reset_in;
    @(posedge clk) disable iff (sys_rst)
    go_w && rst_in |=> rsp.current_count == CNT_ZERO && !rsp.counter_bit
      ##0 (rsp.current_count == CNT_ZERO);
  endproperty
  a_reset_in: assert property (p_reset_in) // RL6
    else $error("reset input did not clear the count");

  property p_up_hold;
    @(posedge clk) disable iff (sys_rst)
    plain_w && req.kind == KIND_UP && cur == CNT_MAX
    |=> rsp.current_count == CNT_MAX && rsp.counter_bit;
  endproperty
  a_up_hold: assert property (p_up_hold) // RL7
    else $error("up counter moved past max");

  property p_down_zero;
    @(posedge clk) disable iff (sys_rst)
    plain_w && req.kind == KIND_DOWN && cur == CNT_ZERO
    |=> rsp.current_count == CNT_ZERO && rsp.counter_bit;
  endproperty
  a_down_zero: assert property (p_down_zero) // RL8
    else $error("down counter left zero or bit low");

  property p_pwr_clear;
    @(posedge clk) sys_rst |=> !sel_bit && !rsp.valid;
  endproperty
  a_pwr_clear: assert property (p_pwr_clear) // RL9
    else $error("counter bit not cleared by reset");

  property p_alt_up_stop;
    @(posedge clk) disable iff (sys_rst)
    plain_w && req.kind == KIND_ALT_UP && cur >= pv
    |=> rsp.current_count == $past(cur) && rsp.counter_bit;
  endproperty
  a_alt_up_stop: assert property (p_alt_up_stop) // RL12
    else $error("alternative up counter passed preset");

  property p_alt_flags;
    @(posedge clk) disable iff (sys_rst)
    go_w && req.kind == KIND_ALT_UP_DOWN
    |=> rsp.upper_reached_flag == (rsp.current_count == $past(pv))
      && rsp.zero_reached_flag == (rsp.current_count == CNT_ZERO);
  endproperty
  a_alt_flags: assert property (p_alt_flags) // RL14
    else $error("up/down reached flags wrong");

  property p_no_edge;
    @(posedge clk) disable iff (sys_rst)
    plain_w && req.kind == KIND_UP && !up_e
    |=> rsp.current_count == $past(cur);
  endproperty
  a_no_edge: assert property (p_no_edge) // RL16
    else $error("counted without a rising edge");

endmodule

`default_nettype wire

/* File: verification/program_model.sv */
// Purpose: Stand-in for the controlling program that posts evaluations.
// Assumes: One step per cycle, launched on the edge after it is posted.
// Notes: The bench alone picks slot numbers, so sharing is deliberate.
`timescale 1ns/1ps
`default_nettype none

module program_model
  import counter_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Step posted by the bench, request seen by the counter bank
  input wire eval_req_t cmd,
  output var eval_req_t req
);
  // ****************************************
  // Request launch
  // ****************************************
  // Registered so the request moves only just after an edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req <= '0;
    end else begin
      req <= cmd;
    end
  end
endmodule

`default_nettype wire

/* File: verification/test_preset_event_counter.sv */
// Purpose: Self-checking bench for the preset event counter bank.
// Assumes: ce high but for one frozen case; evaluations via program model.
// Notes: Wrap cases reach the limits by loading, not by long counting.
`timescale 1ns/1ps
`default_nettype none

module test_preset_event_counter
  import counter_pkg::*;
;
  typedef struct packed {
    logic [7:0] s;
    kind_t k;
    logic [3:0] udlr;
    logic [15:0] pv;
    logic [15:0] cnt;
    logic b;
  } row_t;

  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  eval_req_t cmd = '0;
  eval_req_t req;
  eval_rsp_t rsp;
  int num_errors = 0;
  int samples_checked = 0;

  always #5 clk = ~clk;

  program_model program_model_inst (.clk(clk), .sys_rst(sys_rst),
    .cmd(cmd), .req(req));

  preset_event_counter preset_event_counter_inst (.clk(clk),
    .sys_rst(sys_rst), .ce(ce), .req(req), .rsp(rsp), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Read data is compared with d when w is low
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    if (!w) chk(prdata, d);
    chk({30'h0, pready, pslverr}, {30'h0, 1'b1, e});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ev(input row_t r, input logic want);
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    cmd <= '{1'b1, r.s, r.k, r.udlr[3], r.udlr[2], r.udlr[1], r.udlr[0],
             r.pv};
    @(posedge clk);
    cmd.valid <= 1'b0;
    for (int i = 0; i < 4 && !seen; i++) begin
      @(posedge clk);
      #1;
      seen = (rsp.valid === 1'b1);
    end
    chk({31'h0, seen}, {31'h0, want});
    if (seen && want) begin
      chk({24'h0, rsp.slot}, {24'h0, r.s});
      chk({13'h0, rsp.counter_bit, rsp.upper_reached_flag,
           rsp.zero_reached_flag, rsp.current_count},
          {13'h0, r.b, r.cnt == r.pv, r.cnt == 16'h0, r.cnt});
    end
  endtask

  // ****************************************
  // Ordinary cases: slot, kind, up/down/load/reset, preset, count, bit
  // ****************************************
  row_t rows [0:34] = '{
    '{8'h1, KIND_UP_DOWN, 4'h8, 16'h2, 16'h1, 1'b0},
    '{8'h1, KIND_UP_DOWN, 4'h0, 16'h2, 16'h1, 1'b0},
    '{8'h1, KIND_UP_DOWN, 4'h8, 16'h2, 16'h2, 1'b1},
    '{8'h1, KIND_UP_DOWN, 4'h0, 16'h2, 16'h2, 1'b1},
    '{8'h1, KIND_UP_DOWN, 4'h4, 16'h2, 16'h1, 1'b0},
    '{8'h1, KIND_UP_DOWN, 4'h1, 16'h2, 16'h0, 1'b0},
    '{8'h2, KIND_UP, 4'h8, 16'h1, 16'h1, 1'b1},
    '{8'h2, KIND_UP, 4'h8, 16'h1, 16'h1, 1'b1},
    '{8'h2, KIND_DOWN, 4'h4, 16'h1, 16'h0, 1'b1},
    '{8'h3, KIND_DOWN, 4'h2, 16'h2, 16'h2, 1'b0},
    '{8'h3, KIND_DOWN, 4'h4, 16'h2, 16'h1, 1'b0},
    '{8'h3, KIND_DOWN, 4'h0, 16'h2, 16'h1, 1'b0},
    '{8'h3, KIND_DOWN, 4'h4, 16'h2, 16'h0, 1'b1},
    '{8'h3, KIND_DOWN, 4'h0, 16'h2, 16'h0, 1'b1},
    '{8'h3, KIND_DOWN, 4'h4, 16'h2, 16'h0, 1'b1},
    '{8'h4, KIND_ALT_UP, 4'h8, 16'h1, 16'h1, 1'b1},
    '{8'h4, KIND_ALT_UP, 4'h0, 16'h1, 16'h1, 1'b1},
    '{8'h4, KIND_ALT_UP, 4'h8, 16'h1, 16'h1, 1'b1},
    '{8'h5, KIND_ALT_UP_DOWN, 4'h8, 16'h1, 16'h1, 1'b1},
    '{8'h5, KIND_ALT_UP_DOWN, 4'h0, 16'h1, 16'h1, 1'b1},
    '{8'h5, KIND_ALT_UP_DOWN, 4'h8, 16'h1, 16'h1, 1'b1},
    '{8'h5, KIND_ALT_UP_DOWN, 4'h1, 16'h1, 16'h0, 1'b0},
    '{8'h5, KIND_ALT_UP_DOWN, 4'h2, 16'h1, 16'h1, 1'b1},
    '{8'h6, KIND_ALT_DOWN, 4'h2, 16'h1, 16'h1, 1'b0},
    '{8'h6, KIND_ALT_DOWN, 4'h4, 16'h1, 16'h0, 1'b1},
    '{8'h6, KIND_ALT_DOWN, 4'h0, 16'h1, 16'h0, 1'b1},
    '{8'h6, KIND_ALT_DOWN, 4'h4, 16'h1, 16'h0, 1'b1},
    '{8'h7, KIND_ALT_DOWN, 4'h7, 16'h5, 16'h0, 1'b0},
    '{8'h7, KIND_ALT_DOWN, 4'h0, 16'h5, 16'h0, 1'b1},
    '{8'h7, KIND_ALT_DOWN, 4'h6, 16'h5, 16'h5, 1'b0},
    '{8'h8, KIND_ALT_DOWN, 4'h2, 16'h7FFF, 16'h7FFF, 1'b0},
    '{8'h8, KIND_UP_DOWN, 4'h8, 16'h0, 16'h8000, 1'b0},
    '{8'h8, KIND_UP_DOWN, 4'hC, 16'h0, 16'h7FFF, 1'b1},
    '{8'h9, KIND_ALT_DOWN, 4'h2, 16'h7FFF, 16'h7FFF, 1'b0},
    '{8'h9, KIND_UP, 4'h8, 16'h0, 16'h7FFF, 1'b1}
  };

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, OFS_RETAIN + 8'(4 * i), 32'h0, 1'b0);
    end
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b0, OFS_CTRL, CTRL_RST, 1'b0);
    apb(1'b0, OFS_SLOT_SEL, 32'h0, 1'b0);
    for (int i = 0; i < 35; i++) begin
      ev(rows[i], 1'b1);
    end
    // Slot command clear, then refused accesses
    apb(1'b1, OFS_CMD, 32'h0000_0105, 1'b0);
    apb(1'b1, OFS_SLOT_SEL, 32'h0000_0005, 1'b0);
    apb(1'b0, OFS_SLOT_RD, 32'h0, 1'b0);
    apb(1'b0, 8'h10, 32'h0, 1'b1);
    apb(1'b0, OFS_CMD, 32'h0, 1'b1);
    apb(1'b1, OFS_SLOT_RD, 32'h0000_1234, 1'b1);
    // Evaluation disabled: request ignored
    apb(1'b1, OFS_CTRL, 32'h0, 1'b0);
    ev(rows[0], 1'b0);
    apb(1'b1, OFS_CTRL, 32'h1, 1'b0);
    // Clock enable low: request ignored and slot 1 left as it was
    ce <= 1'b0;
    ev(rows[0], 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    apb(1'b1, OFS_SLOT_SEL, 32'h0000_0001, 1'b0);
    apb(1'b0, OFS_SLOT_RD, 32'h0, 1'b0);
    // Slot 8 retained across reset, slot 9 not
    apb(1'b1, OFS_RETAIN, 32'h0000_0100, 1'b0);
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b1, OFS_SLOT_SEL, 32'h0000_0008, 1'b0);
    apb(1'b0, OFS_SLOT_RD, 32'h0000_7FFF, 1'b0);
    apb(1'b1, OFS_SLOT_SEL, 32'h0000_0009, 1'b0);
    apb(1'b0, OFS_SLOT_RD, 32'h0, 1'b0);
    results();
  end

  // Whole run needs well under 1000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    results();
  end
endmodule

`default_nettype wire
